// ---- verilog/pid_sup_pkg.sv ----
// Constants, types and helpers shared by the PID supervision block
package pid_sup_pkg;

  // ****************************************
  // Codes and limits
  // ****************************************
  localparam logic [15:0] OFF_CODE  = 16'h270F;  // Setting means no function
  localparam logic [15:0] SW_MAX    = 16'h0FA0;  // 400.0 Hz in 0.1 Hz steps
  localparam logic [15:0] SEL_DECEL = 16'h000A;  // Selector group for decel stop
  localparam logic [15:0] MON_SP    = 16'h0034;
  localparam logic [15:0] MON_MV    = 16'h0035;
  localparam logic [15:0] MON_DEV   = 16'h0036;
  localparam logic [15:0] PCT_FULL  = 16'h03E8;  // 100.0 percent
  localparam logic [17:0] DEV_ZERO  = 18'h0_03E8; // Deviation monitor offset

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_AUTOSW = 8'h04;
  localparam logic [7:0] A_ACTSEL = 8'h08;
  localparam logic [7:0] A_UPLIM  = 8'h0C;
  localparam logic [7:0] A_LOLIM  = 8'h10;
  localparam logic [7:0] A_DVLIM  = 8'h14;
  localparam logic [7:0] A_STIME  = 8'h18;
  localparam logic [7:0] A_SLEVEL = 8'h1C;
  localparam logic [7:0] A_SREL   = 8'h20;
  localparam logic [7:0] A_PMSEL  = 8'h24;
  localparam logic [7:0] A_MMSEL  = 8'h28;
  localparam logic [7:0] A_BIAS   = 8'h2C;
  localparam logic [7:0] A_GAIN   = 8'h30;
  localparam logic [7:0] A_PSP    = 8'h34;
  localparam logic [7:0] A_STAT   = 8'h38;
  localparam logic [7:0] A_IRQST  = 8'h3C;
  localparam logic [7:0] A_IRQMSK = 8'h40;
  localparam logic [7:0] A_PMON   = 8'h44;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [15:0] SET_RST = OFF_CODE;
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] MON_RST = MON_SP;
  localparam int          CLK_NS  = 10;
  localparam int          TICK_NS = 100_000_000;  // Detect time step, 0.1 s
  localparam int          TICK_CYC = TICK_NS / CLK_NS;

  typedef enum logic [2:0] {ST_IDLE, ST_OPEN, ST_PID, ST_DECEL, ST_SLEEP, ST_TRIP} state_t;

  typedef struct packed {
    logic fault;
    logic pid_entered;
    logic sleep_end;
    logic sleep_start;
  } irq_t;

  function automatic logic is_off(input logic [15:0] v);
    return v == OFF_CODE;
  endfunction

  function automatic logic [1:0] low_digit(input logic [15:0] sel);
    logic [15:0] d;
    d = (sel >= SEL_DECEL) ? sel - SEL_DECEL : sel;
    return d[1:0];
  endfunction

endpackage

// ---- verilog/pid_supervisor.sv ----
// PID supervision: switchover, limit actions, sleep timer, monitors, APB
//
// What this block does
// R1 - Run open start-up until output reaches switchover frequency, then PID.
// R2 - Once in PID control, stay there even if output frequency falls.
// R3 - Selector 0-3 coasts at suspension start; 10-13 decelerates to stop.
// R4 - Low digit: 1 trips on upper/lower flags, 2 on deviation, 3 both.
// R5 - A limit at the disable code never raises its flag nor a trip.
// R6 - Suspend when PID output stays below detect level longer than detect time.
// R7 - Leave suspension when deviation reaches release setting minus 1000.
// R8 - While suspended: suspension flag on, running off, PID-active on.
// R9 - Host maps the suspension flag with terminal code 70 or 170.
// R10 - Release during deceleration reaccelerates; detect level ignored then.
// R11 - Monitor codes 52, 53, 54; code 54 refused by the meter selector.
// R12 - Deviation monitor reads 1000 at zero deviation.
// R13 - Deviation never reaches the meter output.
// R14 - Both coefficients valid: unitless, meter span from smaller to larger.
// R15 - Both coefficients valid: calibrate with display-coefficient points.
// R16 - Operator calibrates only when stopped and in panel mode; this block accepts bias and gain writes in any state.
// R17 - Panel set point is percent unless both coefficients valid.
// R18 - Detect timer restarts when output returns to detect level.
module pid_supervisor #(
  parameter int TICK_CYC = pid_sup_pkg::TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] pid_freq,
  input  wire logic [15:0] open_freq,
  input  wire logic [15:0] output_freq,
  input  wire logic [15:0] measured_value,
  output logic      [15:0] freq_cmd,
  output logic             running,
  output logic             pid_active,
  output logic             suspend_flag,
  output logic             coast_stop,
  output logic             decel_stop,
  output logic             upper_limit_flag,
  output logic             lower_limit_flag,
  output logic             deviation_limit_flag,
  output logic             loop_fault_trip,
  output logic      [15:0] meter_value,
  output logic      [15:0] meter_full,
  output logic      [15:0] meter_min,
  output logic             coef_mode,
  output logic             irq
);

  // ****************************************
  // Settings and bus
  // ****************************************
  logic        run_r;
  logic [15:0] auto_sw_r, act_sel_r, up_lim_r, lo_lim_r, dv_lim_r;
  logic [15:0] s_time_r, s_level_r, s_rel_r, pm_sel_r, mm_sel_r;
  logic [15:0] bias_r, gain_r, psp_r, pmon_r;
  logic [3:0]  irq_st_r, irq_msk_r, rd_irq_r;
  logic [31:0] prdata_r;
  logic        pready_r, pslverr_r;
  pid_sup_pkg::state_t st_r, st_nxt;
  pid_sup_pkg::irq_t   ev;

  wire setup  = psel && !penable;
  wire wr     = psel && penable && pwrite;
  wire rd_irq = psel && penable && !pwrite && (paddr == pid_sup_pkg::A_IRQST);
  wire [15:0] wd = pwdata[15:0];

  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      pid_sup_pkg::A_CTRL:   rd_mux = {31'h0000_0000, run_r};
      pid_sup_pkg::A_AUTOSW: rd_mux = {16'h0000, auto_sw_r};
      pid_sup_pkg::A_ACTSEL: rd_mux = {16'h0000, act_sel_r};
      pid_sup_pkg::A_UPLIM:  rd_mux = {16'h0000, up_lim_r};
      pid_sup_pkg::A_LOLIM:  rd_mux = {16'h0000, lo_lim_r};
      pid_sup_pkg::A_DVLIM:  rd_mux = {16'h0000, dv_lim_r};
      pid_sup_pkg::A_STIME:  rd_mux = {16'h0000, s_time_r};
      pid_sup_pkg::A_SLEVEL: rd_mux = {16'h0000, s_level_r};
      pid_sup_pkg::A_SREL:   rd_mux = {16'h0000, s_rel_r};
      pid_sup_pkg::A_PMSEL:  rd_mux = {16'h0000, pm_sel_r};
      pid_sup_pkg::A_MMSEL:  rd_mux = {16'h0000, mm_sel_r};
      pid_sup_pkg::A_BIAS:   rd_mux = {16'h0000, bias_r};
      pid_sup_pkg::A_GAIN:   rd_mux = {16'h0000, gain_r};
      pid_sup_pkg::A_PSP:    rd_mux = {16'h0000, psp_r};
      pid_sup_pkg::A_STAT:   rd_mux = {20'h0_0000, st_r, loop_fault_trip,
        deviation_limit_flag, lower_limit_flag, upper_limit_flag,
        suspend_flag, pid_active, running, coef_mode, decel_stop};
      pid_sup_pkg::A_IRQST:  rd_mux = {28'h000_0000, irq_st_r};
      pid_sup_pkg::A_IRQMSK: rd_mux = {28'h000_0000, irq_msk_r};
      pid_sup_pkg::A_PMON:   rd_mux = {16'h0000, pmon_r};
      default:               rd_ok  = 1'b0;
    endcase
  end

  // Read data is latched in setup; the clear then removes only what was seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pready_r  <= 1'b0;
      rd_irq_r  <= 4'h0;
    end else begin
      pready_r <= 1'b1;
      if (setup) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= !rd_ok;
        rd_irq_r  <= irq_st_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r     <= 1'b0;
      auto_sw_r <= pid_sup_pkg::SET_RST;
      act_sel_r <= pid_sup_pkg::SEL_RST;
      up_lim_r  <= pid_sup_pkg::SET_RST;
      lo_lim_r  <= pid_sup_pkg::SET_RST;
      dv_lim_r  <= pid_sup_pkg::SET_RST;
      s_time_r  <= pid_sup_pkg::SET_RST;
      s_level_r <= pid_sup_pkg::SEL_RST;
      s_rel_r   <= pid_sup_pkg::SET_RST;
      pm_sel_r  <= pid_sup_pkg::MON_RST;
      mm_sel_r  <= pid_sup_pkg::MON_RST;
      bias_r    <= pid_sup_pkg::SET_RST;
      gain_r    <= pid_sup_pkg::SET_RST;
      psp_r     <= pid_sup_pkg::SEL_RST;
      irq_msk_r <= 4'h0;
    end else if (wr) begin
      case (paddr)
        pid_sup_pkg::A_CTRL:   run_r     <= pwdata[0];
        pid_sup_pkg::A_AUTOSW: auto_sw_r <= wd;
        pid_sup_pkg::A_ACTSEL: act_sel_r <= wd;
        pid_sup_pkg::A_UPLIM:  up_lim_r  <= wd;
        pid_sup_pkg::A_LOLIM:  lo_lim_r  <= wd;
        pid_sup_pkg::A_DVLIM:  dv_lim_r  <= wd;
        pid_sup_pkg::A_STIME:  s_time_r  <= wd;
        pid_sup_pkg::A_SLEVEL: s_level_r <= wd;
        pid_sup_pkg::A_SREL:   s_rel_r   <= wd;
        pid_sup_pkg::A_PMSEL:  pm_sel_r  <= wd;
        pid_sup_pkg::A_MMSEL: begin
          if (wd != pid_sup_pkg::MON_DEV) begin  // see R11
            mm_sel_r <= wd;
          end
        end
        pid_sup_pkg::A_BIAS:   bias_r    <= wd;
        pid_sup_pkg::A_GAIN:   gain_r    <= wd;
        pid_sup_pkg::A_PSP:    psp_r     <= wd;
        pid_sup_pkg::A_IRQMSK: irq_msk_r <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Set point, deviation and flags
  // ****************************************
  wire coef_ok = !pid_sup_pkg::is_off(bias_r) && !pid_sup_pkg::is_off(gain_r);
  // Coefficient units pass unchanged; percent is capped at full scale
  wire [15:0] sp_eff = coef_ok ? psp_r :                              // see R17
                       ((psp_r > pid_sup_pkg::PCT_FULL) ? pid_sup_pkg::PCT_FULL : psp_r);
  wire signed [17:0] dev     = $signed({2'b00, sp_eff}) - $signed({2'b00, measured_value});
  wire signed [17:0] dev_ofs = dev + $signed(pid_sup_pkg::DEV_ZERO);  // see R12
  wire [17:0]        dev_abs = dev[17] ? 18'(-dev) : 18'(dev);
  wire [15:0] dev_mon = dev_ofs[17] ? 16'h0000 : dev_ofs[15:0];
  wire release_hit = dev_ofs >= $signed({2'b00, s_rel_r});           // see R7
  wire [1:0] dig = pid_sup_pkg::low_digit(act_sel_r);
  wire trip_now = (dig[0] && (upper_limit_flag || lower_limit_flag))  // see R4
               || (dig[1] && deviation_limit_flag);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_limit_flag     <= 1'b0;
      lower_limit_flag     <= 1'b0;
      deviation_limit_flag <= 1'b0;
    end else begin
      upper_limit_flag     <= !pid_sup_pkg::is_off(up_lim_r) && measured_value > up_lim_r;
      lower_limit_flag     <= !pid_sup_pkg::is_off(lo_lim_r) && measured_value < lo_lim_r;
      deviation_limit_flag <= !pid_sup_pkg::is_off(dv_lim_r)  // see R5
                              && dev_abs > {2'b00, dv_lim_r};
    end
  end

  // ****************************************
  // Suspension detect timer
  // ****************************************
  logic [31:0] tick_cnt_r;
  logic [15:0] susp_cnt_r;
  wire tick  = tick_cnt_r == 32'(TICK_CYC - 1);
  wire below = pid_freq < s_level_r;
  wire timing = st_r == pid_sup_pkg::ST_PID && below && !pid_sup_pkg::is_off(s_time_r);
  wire expire = timing && susp_cnt_r > s_time_r;                      // see R6

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // Detect level is not looked at outside PID run, so deceleration ignores it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      susp_cnt_r <= 16'h0000;
    end else if (!timing) begin
      susp_cnt_r <= 16'h0000;                                        // see R18, R10
    end else if (tick && susp_cnt_r != 16'hFFFF) begin
      susp_cnt_r <= susp_cnt_r + 16'h0001;
    end
  end

  // ****************************************
  // Control state machine
  // ****************************************
  wire sw_on = !pid_sup_pkg::is_off(auto_sw_r) && auto_sw_r <= pid_sup_pkg::SW_MAX;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      pid_sup_pkg::ST_IDLE: begin
        if (run_r) begin
          st_nxt = sw_on ? pid_sup_pkg::ST_OPEN : pid_sup_pkg::ST_PID;
        end
      end
      pid_sup_pkg::ST_OPEN: begin
        if (output_freq >= auto_sw_r) begin
          st_nxt = pid_sup_pkg::ST_PID;                               // see R1
        end
      end
      pid_sup_pkg::ST_PID: begin
        if (expire) begin                                             // see R2
          st_nxt = (act_sel_r >= pid_sup_pkg::SEL_DECEL) ?             // see R3
                   pid_sup_pkg::ST_DECEL : pid_sup_pkg::ST_SLEEP;
        end
      end
      pid_sup_pkg::ST_DECEL: begin
        if (release_hit) begin
          st_nxt = pid_sup_pkg::ST_PID;                               // see R10
        end else if (output_freq == 16'h0000) begin
          st_nxt = pid_sup_pkg::ST_SLEEP;
        end
      end
      pid_sup_pkg::ST_SLEEP: begin
        if (release_hit) begin
          st_nxt = pid_sup_pkg::ST_PID;                               // see R7
        end
      end
      pid_sup_pkg::ST_TRIP: st_nxt = pid_sup_pkg::ST_TRIP;
      default: st_nxt = pid_sup_pkg::ST_IDLE;
    endcase
    if (trip_now && st_r != pid_sup_pkg::ST_IDLE) begin
      st_nxt = pid_sup_pkg::ST_TRIP;
    end
    if (!run_r) begin
      st_nxt = pid_sup_pkg::ST_IDLE;
    end
  end

  wire nxt_susp = st_nxt == pid_sup_pkg::ST_DECEL || st_nxt == pid_sup_pkg::ST_SLEEP;
  wire cur_susp = st_r == pid_sup_pkg::ST_DECEL || st_r == pid_sup_pkg::ST_SLEEP;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r            <= pid_sup_pkg::ST_IDLE;
      freq_cmd        <= 16'h0000;
      running         <= 1'b0;
      pid_active      <= 1'b0;
      suspend_flag    <= 1'b0;
      coast_stop      <= 1'b0;
      decel_stop      <= 1'b0;
      loop_fault_trip <= 1'b0;
    end else begin
      st_r            <= st_nxt;
      freq_cmd        <= (st_nxt == pid_sup_pkg::ST_OPEN) ? open_freq :
                         (st_nxt == pid_sup_pkg::ST_PID)  ? pid_freq : 16'h0000;
      running         <= st_nxt == pid_sup_pkg::ST_OPEN || st_nxt == pid_sup_pkg::ST_PID;
      pid_active      <= st_nxt == pid_sup_pkg::ST_PID || nxt_susp;  // see R8
      suspend_flag    <= nxt_susp;
      coast_stop      <= st_nxt == pid_sup_pkg::ST_SLEEP;
      decel_stop      <= st_nxt == pid_sup_pkg::ST_DECEL;
      loop_fault_trip <= st_nxt == pid_sup_pkg::ST_TRIP;
    end
  end

  // ****************************************
  // Monitors and meter
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pmon_r      <= 16'h0000;
      meter_value <= 16'h0000;
      meter_full  <= 16'h0000;
      meter_min   <= 16'h0000;
      coef_mode   <= 1'b0;
    end else begin
      case (pm_sel_r)
        pid_sup_pkg::MON_SP:  pmon_r <= sp_eff;
        pid_sup_pkg::MON_MV:  pmon_r <= measured_value;
        pid_sup_pkg::MON_DEV: pmon_r <= dev_mon;
        default:              pmon_r <= 16'h0000;
      endcase
      // Meter has no deviation leg at all, whatever the selector holds
      case (mm_sel_r)
        pid_sup_pkg::MON_SP: meter_value <= sp_eff;                   // see R13
        pid_sup_pkg::MON_MV: meter_value <= measured_value;
        default:             meter_value <= 16'h0000;
      endcase
      meter_full <= !coef_ok ? pid_sup_pkg::PCT_FULL :                // see R14
                    ((bias_r > gain_r) ? bias_r : gain_r);
      meter_min  <= !coef_ok ? 16'h0000 : ((bias_r > gain_r) ? gain_r : bias_r);
      coef_mode  <= coef_ok;                                          // see R15
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    ev.sleep_start = st_r == pid_sup_pkg::ST_PID && nxt_susp;
    ev.sleep_end   = cur_susp && st_nxt == pid_sup_pkg::ST_PID;
    ev.pid_entered = !cur_susp && st_r != pid_sup_pkg::ST_PID
                     && st_nxt == pid_sup_pkg::ST_PID;
    ev.fault       = st_r != pid_sup_pkg::ST_TRIP && st_nxt == pid_sup_pkg::ST_TRIP;
  end

  // New events win over the read clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_r <= 4'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~(rd_irq ? rd_irq_r : 4'h0)) | ev;
      irq      <= |(irq_st_r & irq_msk_r);
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Assertions
  // ****************************************
  auto_switch_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_r == pid_sup_pkg::ST_OPEN && output_freq >= auto_sw_r && run_r && !trip_now
    |=> st_r == pid_sup_pkg::ST_PID && running)  // see R1
    else $error("switchover to PID missed");
  pid_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_r == pid_sup_pkg::ST_PID && run_r && !trip_now && !expire
    |=> st_r == pid_sup_pkg::ST_PID)  // see R2
    else $error("PID control left without cause");
  stop_kind_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_r == pid_sup_pkg::ST_PID && expire && run_r && !trip_now
    |=> (act_sel_r >= pid_sup_pkg::SEL_DECEL) ? decel_stop : coast_stop)  // see R3
    else $error("wrong stop kind at suspension");
  trip_digit_a: assert property (@(posedge clk) disable iff (!rst_b)
    trip_now && run_r && st_r != pid_sup_pkg::ST_IDLE |=> loop_fault_trip)  // see R4
    else $error("fault trip not raised");
  off_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    pid_sup_pkg::is_off(up_lim_r) |=> !upper_limit_flag)  // see R5
    else $error("disabled limit raised a flag");
  timer_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
    !below |=> susp_cnt_r == 16'h0000)  // see R18
    else $error("detect timer not restarted");
  sleep_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
    timing && susp_cnt_r > s_time_r && run_r && !trip_now |=> suspend_flag)  // see R6
    else $error("suspension not entered");
  release_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur_susp && release_hit && run_r && !trip_now
    |=> st_r == pid_sup_pkg::ST_PID ##0 running)  // see R7
    else $error("release did not resume PID");
  sleep_outs_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur_susp |-> suspend_flag && !running && pid_active)  // see R8
    else $error("suspension outputs wrong");
  meter_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
    mm_sel_r != pid_sup_pkg::MON_DEV)  // see R11
    else $error("meter selector took deviation code");
  meter_span_a: assert property (@(posedge clk) disable iff (!rst_b)
    coef_ok && $stable(bias_r) && $stable(gain_r)
    |=> meter_full >= meter_min && coef_mode)  // see R14
    else $error("meter span wrong");

  sleep_seen_c:   cover property (@(posedge clk) disable iff (!rst_b) ev.sleep_start);
  release_seen_c: cover property (@(posedge clk) disable iff (!rst_b) ev.sleep_end);
  trip_seen_c:    cover property (@(posedge clk) disable iff (!rst_b) ev.fault);
  switch_seen_c:  cover property (@(posedge clk) disable iff (!rst_b)
    st_r == pid_sup_pkg::ST_OPEN ##1 st_r == pid_sup_pkg::ST_PID);

endmodule // pid_supervisor

// ---- tb/drive_stage_model.sv ----
// Behavioural output stage: output frequency slews toward the command
module drive_stage_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] freq_cmd,
  output logic      [15:0] output_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow slew so the switchover level is crossed gradually, never jumped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      output_freq <= 16'h0000;
    end else if (output_freq < freq_cmd) begin
      output_freq <= output_freq + 16'h0001;
    end else if (output_freq > freq_cmd) begin
      output_freq <= output_freq - 16'h0001;
    end
  end
endmodule // drive_stage_model

// ---- tb/pid_supervision_sleep_control_tb_top.sv ----
// Self-checking bench for the PID supervision block
module pid_supervision_sleep_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, rerr, running, pid_active, suspend_flag, coast_stop, decel_stop;
  logic upper_limit_flag, lower_limit_flag, deviation_limit_flag, loop_fault_trip;
  logic coef_mode, irq;
  logic [15:0] pid_freq = 16'h0000, open_freq = 16'h0000, measured_value = 16'h0000;
  logic [15:0] output_freq, freq_cmd, meter_value, meter_full, meter_min;
  int error_cnt = 0;
  int comparisons = 0;

  // ****************************************
  // Clock, design and far side
  // ****************************************
  initial begin
    forever #5 clk = ~clk;
  end
  pid_supervisor #(.TICK_CYC(4)) DUT (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pid_freq(pid_freq), .open_freq(open_freq), .output_freq(output_freq),
    .measured_value(measured_value), .freq_cmd(freq_cmd), .running(running),
    .pid_active(pid_active), .suspend_flag(suspend_flag), .coast_stop(coast_stop),
    .decel_stop(decel_stop), .upper_limit_flag(upper_limit_flag),
    .lower_limit_flag(lower_limit_flag), .deviation_limit_flag(deviation_limit_flag),
    .loop_fault_trip(loop_fault_trip), .meter_value(meter_value),
    .meter_full(meter_full), .meter_min(meter_min), .coef_mode(coef_mode), .irq(irq));
  drive_stage_model stage (.clk(clk), .rst_b(rst_b), .freq_cmd(freq_cmd),
    .output_freq(output_freq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, pid_sup_pkg::A_STAT, 16'h0000);
      n++;
    end while (rdat[11:9] !== s && n < 600);
    chk(32'(rdat[11:9]), 32'(s));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset();
    apb(1'b0, pid_sup_pkg::A_MMSEL, 16'h0000);
    chk(rdat, 32'h0000_0034);
    apb(1'b0, 8'h48, 16'h0000);
    chk(32'(rerr), 32'h0000_0001);
  endtask
  task automatic s_switch();
    open_freq <= 16'h00C8;
    pid_freq  <= 16'h0010;
    apb(1'b1, pid_sup_pkg::A_IRQMSK, 16'h0004);
    apb(1'b1, pid_sup_pkg::A_AUTOSW, 16'h0064);
    apb(1'b1, pid_sup_pkg::A_CTRL, 16'h0001);
    wait_state(3'h1);
    chk(32'({running, pid_active}), 32'h0000_0002);
    wait_state(3'h2);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b0, pid_sup_pkg::A_IRQST, 16'h0000);
    chk(rdat & 32'h0000_0004, 32'h0000_0004);
    repeat (250) @(posedge clk);
    chk(32'({pid_active, irq}), 32'h0000_0002);
    chk(32'(freq_cmd), 32'h0000_0010);
  endtask
  task automatic s_sleep();
    apb(1'b1, pid_sup_pkg::A_SLEVEL, 16'h0100);
    apb(1'b1, pid_sup_pkg::A_STIME, 16'h0002);
    wait_state(3'h4);
    chk(32'({suspend_flag, running, pid_active, coast_stop}), 32'h0000_000B);
    pid_freq <= 16'h0200;
    apb(1'b1, pid_sup_pkg::A_SREL, 16'h03E8);
    wait_state(3'h2);
    apb(1'b1, pid_sup_pkg::A_SREL, pid_sup_pkg::OFF_CODE);
    apb(1'b1, pid_sup_pkg::A_ACTSEL, 16'h000A);
    repeat (40) @(posedge clk);
    pid_freq <= 16'h0010;
    wait_state(3'h3);
    chk(32'({decel_stop, suspend_flag, running}), 32'h0000_0006);
    pid_freq <= 16'h0200;
    apb(1'b1, pid_sup_pkg::A_SREL, 16'h03E8);
    wait_state(3'h2);
  endtask
  task automatic s_limits();
    apb(1'b1, pid_sup_pkg::A_UPLIM, 16'h01F4);
    apb(1'b1, pid_sup_pkg::A_ACTSEL, 16'h000B);
    measured_value <= 16'h0258;
    apb(1'b1, pid_sup_pkg::A_PMSEL, pid_sup_pkg::MON_DEV);
    apb(1'b0, pid_sup_pkg::A_PMON, 16'h0000);
    chk(rdat, 32'h0000_0190);
    wait_state(3'h5);
    chk(32'({upper_limit_flag, lower_limit_flag, deviation_limit_flag, loop_fault_trip}),
        32'h0000_0009);
    apb(1'b1, pid_sup_pkg::A_CTRL, 16'h0000);
    wait_state(3'h0);
  endtask
  task automatic s_monitor();
    apb(1'b1, pid_sup_pkg::A_MMSEL, pid_sup_pkg::MON_DEV);
    apb(1'b0, pid_sup_pkg::A_MMSEL, 16'h0000);
    chk(rdat, 32'h0000_0034);
    // Set point 0 on the meter; the deviation leg would show 400 here
    chk(32'(meter_value), 32'h0000_0000);
    apb(1'b1, pid_sup_pkg::A_PSP, 16'h0500);
    apb(1'b1, pid_sup_pkg::A_PMSEL, pid_sup_pkg::MON_SP);
    apb(1'b0, pid_sup_pkg::A_PMON, 16'h0000);
    chk(rdat, 32'h0000_03E8);
    apb(1'b1, pid_sup_pkg::A_MMSEL, pid_sup_pkg::MON_MV);
    // Coefficients set only with run cleared
    apb(1'b1, pid_sup_pkg::A_BIAS, 16'h0023);
    apb(1'b1, pid_sup_pkg::A_GAIN, 16'h000F);
    repeat (3) @(posedge clk);
    chk(32'(meter_value), 32'h0000_0258);
    chk(32'(coef_mode), 32'h0000_0001);
    chk({meter_full, meter_min}, 32'h0023_000F);
    apb(1'b0, pid_sup_pkg::A_PMON, 16'h0000);
    chk(rdat, 32'h0000_0500);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    s_reset();
    s_switch();
    s_sleep();
    s_limits();
    s_monitor();
    end_of_test();
  end
endmodule // pid_supervision_sleep_control_tb_top
